// ===== design/ecg_defines.svh
// Register offsets, field positions, reset values and timing counts of the event capture block
`ifndef ECG_DEFINES_SVH
`define ECG_DEFINES_SVH
`define ECG_ADDR_MODE 7'h01
`define ECG_ADDR_SYS_EN 7'h04
`define ECG_ADDR_SUP_EN 7'h1C
`define ECG_ADDR_TRX_EN 7'h23
`define ECG_ADDR_WAKE_EN 7'h4C
`define ECG_ADDR_SUMMARY 7'h60
`define ECG_ADDR_SYS_FLG 7'h61
`define ECG_ADDR_SUP_FLG 7'h62
`define ECG_ADDR_TRX_FLG 7'h63
`define ECG_ADDR_WAKE_FLG 7'h64
`define ECG_SYS_PO 4
`define ECG_SYS_OTW 2
`define ECG_SYS_SERIAL_FAILURE_FLAG 1
`define ECG_SYS_WDF 0
`define ECG_SUP_SOVER 2
`define ECG_SUP_SUNDER 1
`define ECG_SUP_MAINU 0
`define ECG_TRX_PNERR 5
`define ECG_TRX_SILENCE 4
`define ECG_TRX_CANFAIL 1
`define ECG_TRX_CANWAKE 0
`define ECG_WK_RISE 1
`define ECG_WK_FALL 0
`define ECG_SYS_FLG_MASK 8'h17
`define ECG_SYS_EN_MASK 8'h06
`define ECG_SUP_MASK 8'h07
`define ECG_TRX_FLG_MASK 8'h33
`define ECG_TRX_EN_MASK 8'h13
`define ECG_WAKE_MASK 8'h03
`define ECG_EN_RESET 8'h00
`define ECG_FLG_RESET 8'h00
`define ECG_MC_SLEEP 3'h1
`define ECG_MC_STANDBY 3'h4
`define ECG_MC_NORMAL 3'h7
`define ECG_CMC_ACTIVE 2'h1
`define ECG_FRAME_BITS 5'h10
`define ECG_HDR_BITS 5'h08
`define ECG_EVENT_DELAY_CYC 2000
`define ECG_RESET_HOLD_CYC 16
`endif

// ===== design/ecg_pkg.sv
// Types shared by the event capture and sleep guard block
package ecg_pkg;

  typedef enum logic [2:0] {
    MD_RESET,
    MD_STANDBY,
    MD_NORMAL,
    MD_SLEEP,
    MD_OVERTEMP
  } ecg_mode_t;

  typedef struct packed {
    logic sclk;
    logic csnB;
    logic sdi;
    logic wakePin;
    logic wdFail;
    logic otWarn;
    logic otShutdown;
    logic sensOver;
    logic sensUnder;
    logic mainUnder;
    logic pnErr;
    logic busSilence;
    logic txdClamp;
    logic canWake;
    logic canRxd;
    logic sleepDisable;
  } ecg_pins_t;

  typedef struct packed {
    ecg_pins_t sync1;
    ecg_pins_t sync2;
    ecg_pins_t prev;
    ecg_mode_t mode;
    logic [15:0] holdCnt;
    logic [7:0] sysEn;
    logic [7:0] supEn;
    logic [7:0] trxEn;
    logic [7:0] wakeEn;
    logic [7:0] sysFlg;
    logic [7:0] supFlg;
    logic [7:0] trxFlg;
    logic [7:0] wakeFlg;
    logic [15:0] delayCnt;
    logic delayRun;
    logic intLow;
    logic rxd;
    logic rstOutB;
    logic poDone;
    logic [4:0] bitCnt;
    logic [15:0] rxSh;
    logic [7:0] txSh;
    logic sdoOe;
  } ecg_state_t;

endpackage

// ===== design/ecg_event_capture.sv
// Event capture, interrupt delay and sleep guard with SPI register access
//
// Contract
// - Clearing any set flag releases the interrupt line high and starts the delay.
// - During the delay, enabled events still set flags but do not pull the line.
// - At delay expiry with any flag set, the line is driven low again.
// - At expiry with all flags cleared, the line stays high.
// - Status and enable registers read at any time without side effects.
// - The delay timer stops at once when the reset output falls.
// - Reset output is low in Reset, Sleep and Overtemp modes.
// - Entering Sleep signals any pending event on the line.
// - CAN and wake-pin wake-ups are regular; everything else is diagnostic.
// - Sleep request with no regular wake-up enabled gives a system reset.
// - Sleep command with any flag pending switches to Reset mode.
// - With sleep disabled, a Sleep command raises serial failure, mode unchanged.
// - Flags clear only on written ones; zeros leave them alone.
// - Summary register bits 3..0 mirror the wake, transceiver, supply, system groups.
// - System flags: power-on 4, overtemp warning 2, serial failure 1, watchdog 0.
// - Supply flags: sensor over 2, sensor under 1, regulator under 0.
// - Transceiver flags: frame error 5, bus silence 4, CAN failure 1, wake 0.
// - CAN failure on regulator undervoltage with mode field 01, or clamped transmit.
// - Wake-pin flags: rising edge bit 1, falling edge bit 0.
// - System enables: overtemp warning bit 2, serial failure bit 1.
// - Supply enables: sensor over bit 2, sensor under bit 1, regulator under 0.
// - Power-on, watchdog and frame error always captured; others need enables.
// - An event captured in Sleep passes through Reset into Standby.
// - Transceiver enables bits 4,1,0; wake-pin enables bits 1,0.
`timescale 1ns/1ps
`include "ecg_defines.svh"

module ecg_event_capture #(
  parameter int EVENT_DELAY_CYCLES = `ECG_EVENT_DELAY_CYC,
  parameter int RESET_HOLD_CYCLES = `ECG_RESET_HOLD_CYC,
  parameter bit HAS_SENSOR_SUPPLY = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spiSclk,
  input wire logic spiCs_b,
  input wire logic spiSdi,
  output logic spiSdo,
  output logic spiSdoOe,
  input wire logic wakePin,
  input wire logic watchdogFail,
  input wire logic overtempWarn,
  input wire logic overtempShutdown,
  input wire logic sensorSupplyOver,
  input wire logic sensorSupplyUnder,
  input wire logic mainRegulatorUnder,
  input wire logic partialNetFrameErr,
  input wire logic busSilence,
  input wire logic txdClamped,
  input wire logic canWakeDetect,
  input wire logic canRxData,
  input wire logic sleepDisableBit,
  input wire logic [1:0] transceiverModeField,
  input wire logic transceiverOffline,
  output logic rxdOut,
  output logic systemResetOut_b,
  output logic mainRegulatorOn
);

  ////////////////////////////////////////////////////////////////
  ecg_pkg::ecg_state_t state_ff;
  ecg_pkg::ecg_state_t nxt_state;
  ecg_pkg::ecg_pins_t pinsRaw;
  ecg_pkg::ecg_pins_t p;
  ecg_pkg::ecg_pins_t q;
  logic sclkRise, sclkFall, csActive, frameStart, frameEnd;
  logic frameOk, wrFrame, rdFrame, modeWr, sleepCmd, spifEvt;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] sysSet, supSet, trxSet, wakeSet;
  logic [7:0] sysClr, supClr, trxClr, wakeClr;
  logic clrAny, capture, anyPendNow, anyPendNxt, regEnabled;
  logic notSleep;

  assign pinsRaw = '{sclk: spiSclk, csnB: spiCs_b, sdi: spiSdi,
    wakePin: wakePin, wdFail: watchdogFail, otWarn: overtempWarn,
    otShutdown: overtempShutdown, sensOver: sensorSupplyOver,
    sensUnder: sensorSupplyUnder, mainUnder: mainRegulatorUnder,
    pnErr: partialNetFrameErr, busSilence: busSilence,
    txdClamp: txdClamped, canWake: canWakeDetect,
    canRxd: canRxData, sleepDisable: sleepDisableBit};

  assign p = state_ff.sync2;
  assign q = state_ff.prev;

  // Register read mux; reads never touch state
  function automatic logic [7:0] rdMux(input logic [6:0] a,
      input ecg_pkg::ecg_state_t s);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `ECG_ADDR_MODE: r = {5'h00, (s.mode == ecg_pkg::MD_NORMAL) ?
        `ECG_MC_NORMAL : `ECG_MC_STANDBY};
      `ECG_ADDR_SYS_EN: r = s.sysEn;
      `ECG_ADDR_SUP_EN: r = s.supEn;
      `ECG_ADDR_TRX_EN: r = s.trxEn;
      `ECG_ADDR_WAKE_EN: r = s.wakeEn;
      `ECG_ADDR_SUMMARY: r = {4'h0, |s.wakeFlg, |s.trxFlg,
        |s.supFlg, |s.sysFlg};
      `ECG_ADDR_SYS_FLG: r = s.sysFlg;
      `ECG_ADDR_SUP_FLG: r = s.supFlg;
      `ECG_ADDR_TRX_FLG: r = s.trxFlg;
      `ECG_ADDR_WAKE_FLG: r = s.wakeFlg;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // SPI frame: A6..A0, read-only bit, D7..D0, MSB first
  assign sclkRise = p.sclk & ~q.sclk;
  assign sclkFall = ~p.sclk & q.sclk;
  assign csActive = ~p.csnB;
  assign frameStart = ~p.csnB & q.csnB;
  assign frameEnd = p.csnB & ~q.csnB;
  assign frameOk = frameEnd && (state_ff.bitCnt == `ECG_FRAME_BITS);
  assign wrFrame = frameOk && !state_ff.rxSh[8];
  assign rdFrame = frameOk && state_ff.rxSh[8];
  assign wrAddr = state_ff.rxSh[15:9];
  assign wrData = state_ff.rxSh[7:0];
  assign notSleep = (state_ff.mode != ecg_pkg::MD_SLEEP);
  assign modeWr = wrFrame && (wrAddr == `ECG_ADDR_MODE) &&
    (state_ff.mode == ecg_pkg::MD_STANDBY ||
     state_ff.mode == ecg_pkg::MD_NORMAL);
  assign sleepCmd = modeWr && (wrData[2:0] == `ECG_MC_SLEEP);
  // Wrong clock count or illegal mode code also count as serial failure
  assign spifEvt = (frameEnd && !frameOk && state_ff.bitCnt != 5'h00) ||
    (modeWr && wrData[2:0] != `ECG_MC_SLEEP &&
     wrData[2:0] != `ECG_MC_STANDBY && wrData[2:0] != `ECG_MC_NORMAL) ||
    (sleepCmd && p.sleepDisable);

  ////////////////////////////////////////////////////////////////
  // Event capture; level inputs are taken on their active edge
  always_comb begin
    sysSet = 8'h00;
    supSet = 8'h00;
    trxSet = 8'h00;
    wakeSet = 8'h00;
    sysSet[`ECG_SYS_PO] = ~state_ff.poDone;
    sysSet[`ECG_SYS_OTW] = p.otWarn & ~q.otWarn & notSleep &
      state_ff.sysEn[`ECG_SYS_OTW];
    sysSet[`ECG_SYS_SERIAL_FAILURE_FLAG] = spifEvt & state_ff.sysEn[`ECG_SYS_SERIAL_FAILURE_FLAG];
    sysSet[`ECG_SYS_WDF] = p.wdFail & ~q.wdFail;
    supSet[`ECG_SUP_SOVER] = HAS_SENSOR_SUPPLY & p.sensOver &
      ~q.sensOver & state_ff.supEn[`ECG_SUP_SOVER];
    supSet[`ECG_SUP_SUNDER] = HAS_SENSOR_SUPPLY & p.sensUnder &
      ~q.sensUnder & state_ff.supEn[`ECG_SUP_SUNDER];
    // Regulator is off in Sleep, so its undervoltage is not captured there
    supSet[`ECG_SUP_MAINU] = p.mainUnder & ~q.mainUnder & notSleep &
      state_ff.supEn[`ECG_SUP_MAINU];
    trxSet[`ECG_TRX_PNERR] = p.pnErr & ~q.pnErr;
    trxSet[`ECG_TRX_SILENCE] = p.busSilence & ~q.busSilence &
      state_ff.trxEn[`ECG_TRX_SILENCE];
    trxSet[`ECG_TRX_CANFAIL] = state_ff.trxEn[`ECG_TRX_CANFAIL] &
      ((transceiverModeField == `ECG_CMC_ACTIVE & p.mainUnder &
        ~q.mainUnder) | (p.txdClamp & ~q.txdClamp));
    trxSet[`ECG_TRX_CANWAKE] = p.canWake & ~q.canWake &
      transceiverOffline & state_ff.trxEn[`ECG_TRX_CANWAKE];
    wakeSet[`ECG_WK_RISE] = p.wakePin & ~q.wakePin &
      state_ff.wakeEn[`ECG_WK_RISE];
    wakeSet[`ECG_WK_FALL] = ~p.wakePin & q.wakePin &
      state_ff.wakeEn[`ECG_WK_FALL];
  end

  // Write-one-to-clear masks
  assign sysClr = (wrFrame && wrAddr == `ECG_ADDR_SYS_FLG) ?
    (wrData & `ECG_SYS_FLG_MASK) : 8'h00;
  assign supClr = (wrFrame && wrAddr == `ECG_ADDR_SUP_FLG) ?
    (wrData & `ECG_SUP_MASK) : 8'h00;
  assign trxClr = (wrFrame && wrAddr == `ECG_ADDR_TRX_FLG) ?
    (wrData & `ECG_TRX_FLG_MASK) : 8'h00;
  assign wakeClr = (wrFrame && wrAddr == `ECG_ADDR_WAKE_FLG) ?
    (wrData & `ECG_WAKE_MASK) : 8'h00;
  assign clrAny = |{sysClr & state_ff.sysFlg, supClr & state_ff.supFlg,
    trxClr & state_ff.trxFlg, wakeClr & state_ff.wakeFlg};
  assign capture = |{sysSet, supSet, trxSet, wakeSet};
  assign anyPendNow = |{state_ff.sysFlg, state_ff.supFlg,
    state_ff.trxFlg, state_ff.wakeFlg};
  assign regEnabled = state_ff.trxEn[`ECG_TRX_CANWAKE] |
    state_ff.wakeEn[`ECG_WK_RISE] | state_ff.wakeEn[`ECG_WK_FALL];
  assign anyPendNxt = |{(state_ff.sysFlg & ~sysClr), (state_ff.supFlg & ~supClr),
    (state_ff.trxFlg & ~trxClr), (state_ff.wakeFlg & ~wakeClr), capture};

  ////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_state.sync1 = pinsRaw;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev = state_ff.sync2;
    nxt_state.poDone = 1'b1;

    // SPI shifter
    if (frameStart) begin
      nxt_state.bitCnt = 5'h00;
      nxt_state.txSh = 8'h00;
      nxt_state.sdoOe = 1'b1;
    end else if (csActive && sclkRise) begin
      nxt_state.rxSh = {state_ff.rxSh[14:0], p.sdi};
      if (state_ff.bitCnt != 5'h1F) begin
        nxt_state.bitCnt = state_ff.bitCnt + 5'h01;
      end
      if (state_ff.bitCnt == `ECG_HDR_BITS - 5'h01) begin
        nxt_state.txSh = rdMux(state_ff.rxSh[6:0], state_ff);
      end
    end else if (csActive && sclkFall && state_ff.bitCnt > `ECG_HDR_BITS) begin
      nxt_state.txSh = {state_ff.txSh[6:0], 1'b0};
    end
    if (frameEnd) begin
      nxt_state.sdoOe = 1'b0;
      nxt_state.bitCnt = 5'h00;
    end

    // Enable registers
    if (wrFrame) begin
      unique case (wrAddr)
        `ECG_ADDR_SYS_EN: nxt_state.sysEn = wrData & `ECG_SYS_EN_MASK;
        `ECG_ADDR_SUP_EN: nxt_state.supEn = wrData & `ECG_SUP_MASK;
        `ECG_ADDR_TRX_EN: nxt_state.trxEn = wrData & `ECG_TRX_EN_MASK;
        `ECG_ADDR_WAKE_EN: nxt_state.wakeEn = wrData & `ECG_WAKE_MASK;
        default: nxt_state.sysEn = state_ff.sysEn;
      endcase
    end

    // Set wins over a clear in the same cycle
    nxt_state.sysFlg = (state_ff.sysFlg & ~sysClr) | sysSet;
    nxt_state.supFlg = (state_ff.supFlg & ~supClr) | supSet;
    nxt_state.trxFlg = (state_ff.trxFlg & ~trxClr) | trxSet;
    nxt_state.wakeFlg = (state_ff.wakeFlg & ~wakeClr) | wakeSet;

    // Operating mode
    if (p.otShutdown) begin
      nxt_state.mode = ecg_pkg::MD_OVERTEMP;
    end else begin
      unique case (state_ff.mode)
        ecg_pkg::MD_RESET: begin
          if (state_ff.holdCnt == 16'h0000) begin
            nxt_state.mode = ecg_pkg::MD_STANDBY;
          end else begin
            nxt_state.holdCnt = state_ff.holdCnt - 16'h0001;
          end
        end
        ecg_pkg::MD_STANDBY, ecg_pkg::MD_NORMAL: begin
          if (sleepCmd) begin
            if (p.sleepDisable) begin
              nxt_state.mode = state_ff.mode;
            end else if (!regEnabled || anyPendNow) begin
              nxt_state.mode = ecg_pkg::MD_RESET;
            end else begin
              nxt_state.mode = ecg_pkg::MD_SLEEP;
            end
          end else if (modeWr && wrData[2:0] == `ECG_MC_STANDBY) begin
            nxt_state.mode = ecg_pkg::MD_STANDBY;
          end else if (modeWr && wrData[2:0] == `ECG_MC_NORMAL) begin
            nxt_state.mode = ecg_pkg::MD_NORMAL;
          end
        end
        ecg_pkg::MD_SLEEP: begin
          if (capture) begin
            nxt_state.mode = ecg_pkg::MD_RESET;
          end
        end
        ecg_pkg::MD_OVERTEMP: nxt_state.mode = ecg_pkg::MD_RESET;
        default: nxt_state.mode = ecg_pkg::MD_RESET;
      endcase
    end
    if (nxt_state.mode == ecg_pkg::MD_RESET &&
        state_ff.mode != ecg_pkg::MD_RESET) begin
      nxt_state.holdCnt = 16'(RESET_HOLD_CYCLES - 1);
    end
    nxt_state.rstOutB = !(nxt_state.mode == ecg_pkg::MD_RESET ||
      nxt_state.mode == ecg_pkg::MD_SLEEP ||
      nxt_state.mode == ecg_pkg::MD_OVERTEMP);

    // Interrupt line and event delay timer
    if (clrAny) begin
      nxt_state.intLow = 1'b0;
      nxt_state.delayRun = 1'b1;
      nxt_state.delayCnt = 16'(EVENT_DELAY_CYCLES - 1);
    end else if (state_ff.delayRun) begin
      if (state_ff.delayCnt == 16'h0000) begin
        nxt_state.delayRun = 1'b0;
        nxt_state.intLow = anyPendNxt;
      end else begin
        nxt_state.delayCnt = state_ff.delayCnt - 16'h0001;
      end
    end else if (capture) begin
      nxt_state.intLow = 1'b1;
    end
    if (nxt_state.mode == ecg_pkg::MD_SLEEP && notSleep) begin
      nxt_state.intLow = anyPendNxt;
    end
    // Falling reset output kills a running delay; pending flags wait for
    // the next captured event to pull the line
    if (state_ff.rstOutB && !nxt_state.rstOutB) begin
      nxt_state.delayRun = 1'b0;
      nxt_state.delayCnt = 16'h0000;
    end
    nxt_state.rxd = transceiverOffline ? ~nxt_state.intLow : p.canRxd;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign spiSdo = state_ff.txSh[7];
  assign spiSdoOe = state_ff.sdoOe;
  assign rxdOut = state_ff.rxd;
  assign systemResetOut_b = state_ff.rstOutB;
  assign mainRegulatorOn = (state_ff.mode != ecg_pkg::MD_SLEEP);

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_clear_release: assert property (clrAny && nxt_state.rstOutB |=> !state_ff.intLow &&
    state_ff.delayRun) else $error("clear did not release line");
  a_delay_quiet: assert property (state_ff.delayRun |-> !state_ff.intLow)
    else $error("line pulled during delay");
  a_expiry_low: assert property (state_ff.delayRun &&
    state_ff.delayCnt == 16'h0000 && !clrAny && nxt_state.rstOutB &&
    anyPendNxt |=> state_ff.intLow) else $error("expiry missed pending");
  a_expiry_high: assert property (state_ff.delayRun &&
    state_ff.delayCnt == 16'h0000 && !clrAny && !anyPendNxt &&
    nxt_state.mode == state_ff.mode |=> !state_ff.intLow)
    else $error("line low without pending");
  a_read_keeps: assert property (rdFrame && !p.otShutdown |=>
    (state_ff.trxFlg & $past(state_ff.trxFlg)) == $past(state_ff.trxFlg))
    else $error("read changed flags");
  a_timer_stop: assert property ($fell(state_ff.rstOutB) |->
    !state_ff.delayRun) else $error("delay ran past reset");
  a_reset_out: assert property (state_ff.mode inside {ecg_pkg::MD_RESET,
    ecg_pkg::MD_SLEEP, ecg_pkg::MD_OVERTEMP} |-> !systemResetOut_b)
    else $error("reset output high in low mode");
  a_sleep_guard: assert property (sleepCmd && !p.sleepDisable &&
    !p.otShutdown && (anyPendNow || !regEnabled) |=>
    state_ff.mode == ecg_pkg::MD_RESET) else $error("sleep guard");
  a_sleep_pend: assert property (sleepCmd && anyPendNow &&
    !p.sleepDisable && !p.otShutdown |=> state_ff.mode ==
    ecg_pkg::MD_RESET ##1 !systemResetOut_b)
    else $error("pending sleep not reset");
  a_sleep_lock: assert property (sleepCmd && p.sleepDisable &&
    !p.otShutdown |=> state_ff.mode == $past(state_ff.mode))
    else $error("sleep lock ignored");
  a_no_spont_clr: assert property (!wrFrame |=>
    (state_ff.wakeFlg & $past(state_ff.wakeFlg)) == $past(state_ff.wakeFlg))
    else $error("flag cleared without write");
  a_sleep_wake: assert property (state_ff.mode == ecg_pkg::MD_SLEEP &&
    capture && !p.otShutdown |=> state_ff.mode == ecg_pkg::MD_RESET ##[1:300]
    state_ff.mode != ecg_pkg::MD_RESET) else $error("no wake exit");

  c_delay_relow: cover property (clrAny ##[1:1000] $fell(state_ff.delayRun)
    ##1 state_ff.intLow);
  c_sleep_enter: cover property (state_ff.mode == ecg_pkg::MD_SLEEP);
  c_sleep_exit: cover property (state_ff.mode == ecg_pkg::MD_SLEEP ##1
    state_ff.mode == ecg_pkg::MD_RESET);

endmodule

// ===== testbench/ecg_host_model.sv
// Host microcontroller model: SPI master for the event capture block
`timescale 1ns/1ps
module ecg_host_model (
  input wire logic mclk,
  input wire logic spiSdo,
  input wire logic spiSdoOe,
  output logic spiSclk,
  output logic spiCs_b,
  output logic spiSdi
);
  logic oeInFrame;
  initial begin
    oeInFrame = 1'b0;
    spiSclk = 1'b0;
    spiCs_b = 1'b1;
    spiSdi = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Half period of 10 cycles: pins pass two sync flops and an edge flop first
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] wd,
    output logic [7:0] q);
    logic [15:0] f;
    f = {a, rd, wd};
    q = 8'h00;
    cyc(1);
    spiCs_b = 1'b0;
    cyc(6);
    for (int i = 15; i >= 0; i--) begin
      spiSdi = f[i];
      cyc(10);
      if (i < 8) q = {q[6:0], spiSdo};
      if (i == 0) oeInFrame = spiSdoOe;
      spiSclk = 1'b1;
      cyc(10);
      spiSclk = 1'b0;
    end
    cyc(6);
    spiCs_b = 1'b1;
    // Idle data is not held at the last bit, so stale values cannot pass
    spiSdi = ~spiSdi;
    cyc(8);
  endtask
endmodule

// ===== testbench/tb_event_capture_and_sleep_guard.sv
// Self-checking bench for the event capture and sleep guard block
`timescale 1ns/1ps
module tb_event_capture_and_sleep_guard;
  logic mclk, rst_b, spiSclk, spiCs_b, spiSdi, spiSdo, canRxData, overtempShutdown;
  logic wakePin, watchdogFail, overtempWarn, sensorSupplyOver, sensorSupplyUnder;
  logic mainRegulatorUnder, partialNetFrameErr, busSilence, txdClamped, canWakeDetect;
  logic sleepDisableBit, transceiverOffline, rxdOut, systemResetOut_b, mainRegulatorOn;
  logic [1:0] transceiverModeField;
  logic [9:0] ev;
  logic spiSdoOe;
  logic [7:0] q, m, v;
  logic [31:0] seed;
  int n_mismatch, n_checks, cycles;
  localparam logic [6:0] FREG [11] = '{7'h61, 7'h61, 7'h62, 7'h62, 7'h62, 7'h63,
    7'h63, 7'h63, 7'h63, 7'h64, 7'h64};
  localparam logic [6:0] EREG [11] = '{7'h00, 7'h04, 7'h1C, 7'h1C, 7'h1C, 7'h00,
    7'h23, 7'h23, 7'h23, 7'h4C, 7'h4C};
  localparam int FBIT [11] = '{0, 2, 2, 1, 0, 5, 4, 1, 0, 1, 0};
  localparam int EBIT [11] = '{0, 2, 2, 1, 0, 0, 4, 1, 0, 1, 0};
  localparam int INP [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 9};
  localparam logic [6:0] EA [4] = '{7'h04, 7'h1C, 7'h23, 7'h4C};
  localparam logic [7:0] EM [4] = '{8'h06, 8'h07, 8'h13, 8'h03};
  assign {wakePin, canWakeDetect, txdClamped, busSilence, partialNetFrameErr,
    mainRegulatorUnder, sensorSupplyUnder, sensorSupplyOver, overtempWarn, watchdogFail} = ev;

  ecg_event_capture #(.EVENT_DELAY_CYCLES(400), .RESET_HOLD_CYCLES(16)) i_dut (
    .mclk, .rst_b, .spiSclk, .spiCs_b, .spiSdi, .spiSdo, .spiSdoOe, .wakePin,
    .watchdogFail, .overtempWarn, .overtempShutdown, .sensorSupplyOver, .sensorSupplyUnder,
    .mainRegulatorUnder, .partialNetFrameErr, .busSilence, .txdClamped, .canWakeDetect,
    .canRxData, .sleepDisableBit, .transceiverModeField, .transceiverOffline, .rxdOut,
    .systemResetOut_b, .mainRegulatorOn);
  ecg_host_model i_host (.mclk, .spiSdo, .spiSdoOe, .spiSclk, .spiCs_b, .spiSdi);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    i_host.cyc(n);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer(a, 1'b0, d, q);
  endtask
  task automatic rdc(input string nm, input logic [6:0] a, input logic [7:0] exp);
    i_host.xfer(a, 1'b1, 8'h00, q);
    chk(nm, q, exp);
  endtask
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    cyc(8);
    ev[i] = 1'b0;
    cyc(8);
  endtask
  // Bounded wait on the reset output or the interrupt line, then compare
  task automatic waitFor(input string nm, input bit rsel, input logic lv, input int n);
    logic s;
    s = rsel ? systemResetOut_b : rxdOut;
    for (int k = 0; k < n && s !== lv; k++) begin
      cyc(1);
      s = rsel ? systemResetOut_b : rxdOut;
    end
    chk(nm, {7'h00, s}, {7'h00, lv});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    ev = 10'h000;
    canRxData = 1'b1;
    overtempShutdown = 1'b0;
    sleepDisableBit = 1'b0;
    transceiverModeField = 2'h0;
    transceiverOffline = 1'b1;
    seed = 32'h0000A562;
    repeat (10) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    waitFor("reset out", 1'b1, 1'b1, 100);
    chk("line", {7'h00, rxdOut}, 8'h00);
    rdc("sys flags", 7'h61, 8'h10);
    wr(7'h61, 8'h00);
    rdc("sys flags", 7'h61, 8'h10);
    wr(7'h61, 8'h10);
    chk("line", {7'h00, rxdOut}, 8'h01);
    pulse(0);
    chk("line", {7'h00, rxdOut}, 8'h01);
    rdc("sys flags", 7'h61, 8'h01);
    chk("line", {7'h00, rxdOut}, 8'h01);
    waitFor("line", 1'b0, 1'b0, 100);
    wr(7'h61, 8'h01);
    cyc(450);
    chk("line", {7'h00, rxdOut}, 8'h01);
    rdc("unmapped", 7'h10, 8'h00);
    for (int r = 0; r < 3; r++) begin
      seed = xs(seed);
      v = seed[7:0];
      for (int e = 0; e < 4; e++) begin
        wr(EA[e], v);
        rdc("enable", EA[e], v & EM[e]);
      end
    end
    for (int e = 0; e < 4; e++) wr(EA[e], 8'h00);
    for (int k = 0; k < 11; k++) begin
      m = 8'h01 << FBIT[k];
      pulse(INP[k]);
      rdc("flag off", FREG[k], (EREG[k] == 7'h00) ? m : 8'h00);
      wr(EREG[k], 8'h01 << EBIT[k]);
      pulse(INP[k]);
      rdc("flag on", FREG[k], m);
      rdc("summary", 7'h60, 8'h01 << (FREG[k] - 7'h61));
      wr(FREG[k], ~m);
      rdc("flag kept", FREG[k], m);
      wr(FREG[k], m);
      rdc("flag clr", FREG[k], 8'h00);
      wr(EREG[k], 8'h00);
    end
    wr(7'h23, 8'h02);
    transceiverModeField = 2'h1;
    pulse(4);
    rdc("can fail", 7'h63, 8'h02);
    wr(7'h63, 8'h02);
    transceiverModeField = 2'h0;
    wr(7'h04, 8'h02);
    sleepDisableBit = 1'b1;
    wr(7'h01, 8'h01);
    chk("reset out", {7'h00, systemResetOut_b}, 8'h01);
    rdc("sys flags", 7'h61, 8'h02);
    wr(7'h61, 8'h02);
    sleepDisableBit = 1'b0;
    wr(7'h01, 8'h01);
    chk("reset out", {7'h00, systemResetOut_b}, 8'h00);
    waitFor("reset out", 1'b1, 1'b1, 100);
    pulse(0);
    wr(7'h4C, 8'h02);
    wr(7'h01, 8'h01);
    chk("reset out", {7'h00, systemResetOut_b}, 8'h00);
    waitFor("reset out", 1'b1, 1'b1, 100);
    wr(7'h4C, 8'h02);
    wr(7'h61, 8'h01);
    wr(7'h01, 8'h01);
    chk("reset out", {7'h00, systemResetOut_b}, 8'h00);
    chk("regulator", {7'h00, mainRegulatorOn}, 8'h00);
    pulse(9);
    waitFor("reset out", 1'b1, 1'b1, 60);
    chk("regulator", {7'h00, mainRegulatorOn}, 8'h01);
    waitFor("line", 1'b0, 1'b0, 8);
    rdc("wake flags", 7'h64, 8'h02);
    rdc("mode", 7'h01, 8'h04);
    chk("sdo enable", {7'h00, i_host.oeInFrame}, 8'h01);
    chk("sdo idle", {7'h00, spiSdoOe}, 8'h00);
    wr(7'h01, 8'h07);
    rdc("mode", 7'h01, 8'h07);
    wr(7'h01, 8'h03);
    rdc("mode", 7'h01, 8'h07);
    rdc("sys flags", 7'h61, 8'h02);
    transceiverOffline = 1'b0;
    canRxData = 1'b0;
    cyc(5);
    chk("line online", {7'h00, rxdOut}, 8'h00);
    canRxData = 1'b1;
    cyc(5);
    chk("line online", {7'h00, rxdOut}, 8'h01);
    transceiverOffline = 1'b1;
    overtempShutdown = 1'b1;
    cyc(5);
    chk("reset out", {7'h00, systemResetOut_b}, 8'h00);
    overtempShutdown = 1'b0;
    waitFor("reset out", 1'b1, 1'b1, 100);
    finish_test();
  end
endmodule
